// File: hdl/uab_uart.sv
// Single channel serial transmitter and receiver with an APB register slave.
//
// What this block does
// - One serial channel, at most 115.2 kbps on the system clock.
// - Command bits: interrupts, parity, odd/even, clock source.
// - Interrupt on byte received and byte sent.
// - Status tells receive from transmit interrupt cause.
// - Frame, overrun, parity errors flagged per byte.
// - Auto calibration gives standard rates from index.
// - Ten calibrated rates; timed on the system clock.
// - Without calibration the prescaler sets the rate.
`timescale 1ns/10ps
`default_nettype none
`include "uab_cfg.svh"

module uab_uart (
    input  wire logic                    mclk_in,
    input  wire logic                    rst_n_in,
    input  wire logic                    psel_in,
    input  wire logic                    penable_in,
    input  wire logic                    pwrite_in,
    input  wire logic [`UAB_ADDR_W-1:0]  paddr_in,
    input  wire logic [31:0]             pwdata_in,
    output logic      [31:0]             prdata_out,
    output logic                         pready_out,
    output logic                         pslverr_out,
    input  wire logic                    rxd_in,
    input  wire logic                    rosc_in,
    output logic                         txd_out,
    output logic                         irq_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // Bit period lookup for the calibrated rates, in clock cycles minus one.
    function automatic logic [16:0] rate_div(input logic [3:0] idx);
        integer r;
        begin
            case (idx)
                4'h0:    r = `UAB_RATE_0;
                4'h1:    r = `UAB_RATE_1;
                4'h2:    r = `UAB_RATE_2;
                4'h3:    r = `UAB_RATE_3;
                4'h4:    r = `UAB_RATE_4;
                4'h5:    r = `UAB_RATE_5;
                4'h6:    r = `UAB_RATE_6;
                4'h7:    r = `UAB_RATE_7;
                4'h8:    r = `UAB_RATE_8;
                default: r = `UAB_RATE_9;
            endcase
            rate_div = 17'((`UAB_CLK_HZ / r) - 1);
        end
    endfunction

    // Shortest bit period allowed on the system clock.
    localparam logic [16:0] DIV_MAX = 17'((`UAB_CLK_HZ / `UAB_MAX_BPS) - 1);
    localparam logic [16:0] DIV_SLOW = 17'((`UAB_CLK_HZ / `UAB_RATE_0) - 1);

    ////////////////////////////////////////////////////////////////////////////////
    // Software state.
    uab_pkg::uab_cmd_t   cmd;          // Command settings.
    logic [3:0]          baud_sel;     // Calibrated rate index.
    logic [15:0]         presc;        // Free prescaler, cycles per bit minus one.
    logic                rx_flag;      // Byte received, sticky.
    logic                tx_flag;      // Byte sent, sticky.
    logic                frm_err;      // Stop bit was low.
    logic                ovr_err;      // Byte arrived over an unread one.
    logic                par_err;      // Parity mismatch.
    logic                rx_full;      // Receive buffer holds an unread byte.
    logic [7:0]          rx_buf;       // Last received byte.

    // Line state.
    uab_pkg::uab_tx_st_t tx_st;
    uab_pkg::uab_rx_st_t rx_st;
    logic [16:0]         tx_cnt;       // Ticks left in the current sent bit.
    logic [16:0]         rx_cnt;       // Ticks left to the next sample point.
    logic [7:0]          tx_sh;        // Outgoing shift register.
    logic [7:0]          rx_sh;        // Incoming shift register.
    logic [2:0]          tx_bit;       // Data bit index on transmit.
    logic [2:0]          rx_bit;       // Data bit index on receive.
    logic                tx_par;       // Running parity of sent bits.
    logic                rx_s1;        // Receive pin synchroniser, first stage.
    logic                rx_s2;        // Receive pin synchroniser, second stage.
    logic                rx_s3;        // Delayed copy for start edge detection.
    logic                rosc_s1;      // Oscillator pin synchroniser, first stage.
    logic                rosc_s2;      // Oscillator pin synchroniser, second stage.
    logic                rosc_s3;      // Delayed copy for edge detection.

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode and completion.
    wire        bus_first = psel_in & penable_in & ~pready_out;  // First access cycle.
    wire        bus_done  = psel_in & penable_in & pready_out;   // Completing edge.
    wire        sel_cmd   = (paddr_in == `UAB_OFF_CMD);
    wire        sel_baud  = (paddr_in == `UAB_OFF_BAUD);
    wire        sel_presc = (paddr_in == `UAB_OFF_PRESC);
    wire        sel_stat  = (paddr_in == `UAB_OFF_STATUS);
    wire        sel_data  = (paddr_in == `UAB_OFF_DATA);
    wire        mapped    = sel_cmd | sel_baud | sel_presc | sel_stat | sel_data;
    wire        wr_ok     = bus_done & pwrite_in & mapped;
    wire        rd_data   = bus_done & ~pwrite_in & sel_data;
    wire        tx_busy   = (tx_st != uab_pkg::TX_IDLE);
    wire [6:0]  status    = {rx_full, tx_busy, par_err, ovr_err, frm_err, tx_flag, rx_flag};
    wire [31:0] rd_mux    = sel_cmd   ? {26'h0, cmd}      :
                            sel_baud  ? {28'h0, baud_sel} :
                            sel_presc ? {16'h0, presc}    :
                            sel_stat  ? {25'h0, status}   :
                            sel_data  ? {24'h0, rx_buf}   : 32'h0;
    wire        clr_stat  = wr_ok & sel_stat;
    wire        tx_start  = wr_ok & sel_data & ~tx_busy;

    // Bit timebase: system clock, or rising edges of the oscillator pin.
    wire        tick      = ~cmd.clk_src | cmd.autocal | (rosc_s2 & ~rosc_s3);
    wire [16:0] presc_div = (cmd.clk_src | ({1'b0, presc} >= DIV_MAX)) ? {1'b0, presc} : DIV_MAX;
    wire [16:0] bit_div   = cmd.autocal ? rate_div(baud_sel) : presc_div;

    // Line events.
    wire        tx_exp    = tick & (tx_cnt == 17'h0);
    wire        rx_exp    = tick & (rx_cnt == 17'h0);
    wire        tx_done   = tx_exp & (tx_st == uab_pkg::TX_STOP);
    wire        rx_done   = rx_exp & (rx_st == uab_pkg::RX_STOP);
    wire        rx_bad_p  = (^rx_sh ^ rx_s2) != cmd.par_odd;
    wire        rx_fall   = rx_s3 & ~rx_s2;
    wire        irq_next  = (rx_flag & cmd.rx_ie) | (tx_flag & cmd.tx_ie);

    ////////////////////////////////////////////////////////////////////////////////
    // Bus answer: one wait state, then ready with registered data.
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0;
        end else begin
            pready_out  <= bus_first;
            pslverr_out <= bus_first & ~mapped;
            if (bus_first) begin
                prdata_out <= rd_mux;
            end
        end
    end

    // Software registers; writes land on the completing edge.
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cmd      <= uab_pkg::uab_cmd_t'(`UAB_CMD_RST);
            baud_sel <= `UAB_BAUD_RST;
            presc    <= `UAB_PRESC_RST;
        end else if (wr_ok) begin
            if (sel_cmd) begin
                cmd <= uab_pkg::uab_cmd_t'(pwdata_in[5:0]);
            end
            if (sel_baud) begin
                baud_sel <= pwdata_in[3:0];
            end
            if (sel_presc) begin
                presc <= pwdata_in[15:0];
            end
        end
    end

    // Sticky status; a hardware set in the clearing cycle wins.
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_flag <= 1'b0;
            tx_flag <= 1'b0;
            frm_err <= 1'b0;
            ovr_err <= 1'b0;
            par_err <= 1'b0;
            rx_full <= 1'b0;
            rx_buf  <= 8'h0;
            irq_out <= 1'b0;
        end else begin
            rx_flag <= rx_done | (rx_flag & ~(clr_stat & pwdata_in[`UAB_ST_RX_FLAG]));
            tx_flag <= tx_done | (tx_flag & ~(clr_stat & pwdata_in[`UAB_ST_TX_FLAG]));
            frm_err <= (rx_done & ~rx_s2) |
                       (frm_err & ~(clr_stat & pwdata_in[`UAB_ST_FRM_ERR]));
            ovr_err <= (rx_done & rx_full & ~rd_data) |
                       (ovr_err & ~(clr_stat & pwdata_in[`UAB_ST_OVR_ERR]));
            par_err <= (rx_exp & (rx_st == uab_pkg::RX_PAR) & rx_bad_p) |
                       (par_err & ~(clr_stat & pwdata_in[`UAB_ST_PAR_ERR]));
            rx_full <= rx_done | (rx_full & ~rd_data);
            if (rx_done) begin
                rx_buf <= rx_sh;
            end
            irq_out <= irq_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; the second stage and its delayed copy feed logic, the first stage does not.
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_s1   <= 1'b1;
            rx_s2   <= 1'b1;
            rx_s3   <= 1'b1;
            rosc_s1 <= 1'b0;
            rosc_s2 <= 1'b0;
            rosc_s3 <= 1'b0;
        end else begin
            rx_s1   <= rxd_in;
            rx_s2   <= rx_s1;
            rx_s3   <= rx_s2;
            rosc_s1 <= rosc_in;
            rosc_s2 <= rosc_s1;
            rosc_s3 <= rosc_s2;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Transmitter. A data write while busy is dropped, not queued.
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_st   <= uab_pkg::TX_IDLE;
            tx_cnt  <= 17'h0;
            tx_sh   <= 8'h0;
            tx_bit  <= 3'h0;
            tx_par  <= 1'b0;
            txd_out <= 1'b1;
        end else begin
            if (tick & (tx_cnt != 17'h0)) begin
                tx_cnt <= tx_cnt - 17'h1;
            end
            unique case (tx_st)
                uab_pkg::TX_IDLE: begin
                    txd_out <= 1'b1;
                    if (tx_start) begin
                        tx_st   <= uab_pkg::TX_START;
                        tx_sh   <= pwdata_in[7:0];
                        tx_par  <= cmd.par_odd;
                        tx_cnt  <= bit_div;
                        txd_out <= 1'b0;
                    end
                end
                uab_pkg::TX_START, uab_pkg::TX_DATA: begin
                    if (tx_exp) begin
                        txd_out <= tx_sh[0];
                        tx_par  <= tx_par ^ tx_sh[0];
                        tx_sh   <= {1'b0, tx_sh[7:1]};
                        tx_cnt  <= bit_div;
                        tx_bit  <= (tx_st == uab_pkg::TX_START) ? 3'h0 : tx_bit + 3'h1;
                        tx_st   <= uab_pkg::TX_DATA;
                        if ((tx_st == uab_pkg::TX_DATA) & (tx_bit == 3'h7)) begin
                            txd_out <= cmd.par_en ? tx_par : 1'b1;
                            tx_st   <= cmd.par_en ? uab_pkg::TX_PAR : uab_pkg::TX_STOP;
                        end
                    end
                end
                uab_pkg::TX_PAR: begin
                    if (tx_exp) begin
                        txd_out <= 1'b1;
                        tx_cnt  <= bit_div;
                        tx_st   <= uab_pkg::TX_STOP;
                    end
                end
                uab_pkg::TX_STOP: begin
                    if (tx_exp) begin
                        tx_st <= uab_pkg::TX_IDLE;
                    end
                end
                default: begin
                    tx_st <= uab_pkg::TX_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Receiver. Samples at bit centres; a start shorter than half a bit is
    // treated as noise. It re-arms at mid stop bit so back to back frames fit.
    // A start needs a falling edge, so a line held low after a framing error
    // does not open a false frame.
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_st  <= uab_pkg::RX_IDLE;
            rx_cnt <= 17'h0;
            rx_sh  <= 8'h0;
            rx_bit <= 3'h0;
        end else begin
            if (tick & (rx_cnt != 17'h0)) begin
                rx_cnt <= rx_cnt - 17'h1;
            end
            unique case (rx_st)
                uab_pkg::RX_IDLE: begin
                    if (rx_fall) begin
                        rx_cnt <= bit_div >> 1;
                        rx_st  <= uab_pkg::RX_START;
                    end
                end
                uab_pkg::RX_START: begin
                    if (rx_exp) begin
                        rx_cnt <= bit_div;
                        rx_bit <= 3'h0;
                        rx_st  <= rx_s2 ? uab_pkg::RX_IDLE : uab_pkg::RX_DATA;
                    end
                end
                uab_pkg::RX_DATA: begin
                    if (rx_exp) begin
                        rx_sh  <= {rx_s2, rx_sh[7:1]};
                        rx_cnt <= bit_div;
                        rx_bit <= rx_bit + 3'h1;
                        if (rx_bit == 3'h7) begin
                            rx_st <= cmd.par_en ? uab_pkg::RX_PAR : uab_pkg::RX_STOP;
                        end
                    end
                end
                uab_pkg::RX_PAR: begin
                    if (rx_exp) begin
                        rx_cnt <= bit_div;
                        rx_st  <= uab_pkg::RX_STOP;
                    end
                end
                uab_pkg::RX_STOP: begin
                    if (rx_exp) begin
                        rx_st <= uab_pkg::RX_IDLE;
                    end
                end
                default: begin
                    rx_st <= uab_pkg::RX_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks on the driven behaviour.
    tx_idle_high_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (tx_st == uab_pkg::TX_IDLE) && !$past(tx_start) |-> txd_out)
        else $error("transmit line not high while idle");
    tx_start_bit_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        tx_start |=> !txd_out && (tx_st == uab_pkg::TX_START))
        else $error("accepted byte did not open with a low start bit");
    tx_event_flag_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        tx_done |=> tx_flag && (tx_st == uab_pkg::TX_IDLE))
        else $error("sent byte did not set the transmit flag");
    rx_event_flag_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        rx_done |=> rx_flag && rx_full && (rx_buf == $past(rx_sh)))
        else $error("received byte not delivered with its flag");
    irq_cause_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        ((rx_flag && cmd.rx_ie) || (tx_flag && cmd.tx_ie)) |=> irq_out)
        else $error("enabled pending cause did not raise the interrupt");
    overrun_flag_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        rx_done && rx_full && !rd_data |=> ovr_err)
        else $error("byte over an unread one not flagged as overrun");
    frame_flag_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        rx_done && !rx_s2 |=> frm_err)
        else $error("low stop bit not flagged as framing error");
    autocal_rate_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        cmd.autocal && (baud_sel == 4'h0) |-> (bit_div == DIV_SLOW))
        else $error("calibrated slowest rate has the wrong bit period");
    presc_rate_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        !cmd.autocal && cmd.clk_src |-> (bit_div == {1'b0, presc}))
        else $error("prescaler value not used as bit period");
    rate_ceiling_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        !cmd.clk_src || cmd.autocal |-> (bit_div >= DIV_MAX))
        else $error("bit rate above the ceiling on the system clock");
    apb_ready_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        psel_in && penable_in && !pready_out |=> pready_out ##1 !pready_out)
        else $error("bus answer not a single ready cycle after one wait");

endmodule

`default_nettype wire

// File: common/uab_cfg.svh
// Offsets, field positions, reset values and timing counts of the serial block.
`ifndef UAB_CFG_SVH
`define UAB_CFG_SVH
`define UAB_CLK_HZ      100000000
`define UAB_MAX_BPS     115200
`define UAB_ADDR_W      12
`define UAB_OFF_CMD     12'h000
`define UAB_OFF_BAUD    12'h004
`define UAB_OFF_PRESC   12'h008
`define UAB_OFF_STATUS  12'h00c
`define UAB_OFF_DATA    12'h010
`define UAB_CMD_RST     6'h00
`define UAB_BAUD_RST    4'h3
`define UAB_PRESC_RST   16'h28af
`define UAB_ST_RX_FLAG  0
`define UAB_ST_TX_FLAG  1
`define UAB_ST_FRM_ERR  2
`define UAB_ST_OVR_ERR  3
`define UAB_ST_PAR_ERR  4
`define UAB_ST_TX_BUSY  5
`define UAB_ST_RX_FULL  6
`define UAB_RATE_0      1200
`define UAB_RATE_1      2400
`define UAB_RATE_2      4800
`define UAB_RATE_3      9600
`define UAB_RATE_4      19200
`define UAB_RATE_5      38400
`define UAB_RATE_6      51200
`define UAB_RATE_7      57600
`define UAB_RATE_8      102400
`define UAB_RATE_9      115200
`endif

// File: common/uab_pkg.sv
// Types shared by the serial block: command fields and line state machines.
package uab_pkg;
    // Command register fields, rx_ie in bit 0.
    typedef struct packed {
        logic autocal;
        logic clk_src;
        logic par_odd;
        logic par_en;
        logic tx_ie;
        logic rx_ie;
    } uab_cmd_t;
    // Transmit line states.
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} uab_tx_st_t;
    // Receive line states.
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} uab_rx_st_t;
endpackage

// File: tb/uab_far_end.sv
// Remote serial device model that faces the block's line pins.
`timescale 1ns/10ps
`default_nettype none
module uab_far_end (
    input  wire logic mclk_in,
    input  wire logic txd_in,
    output logic      rxd_out
);
    int bit_cyc = 64; // Bit time in system clock cycles, set by the bench.
    initial rxd_out = 1'b1; // The line idles high between frames.
    // Sends one frame; a wrong parity or a low stop bit only when asked.
    task automatic send(input logic [7:0] b, input logic pe, input logic po,
                        input logic bad_par, input logic bad_stop);
        rxd_out <= 1'b0; // Start bit is low.
        repeat (bit_cyc) @(posedge mclk_in);
        for (int i = 0; i < 8; i++) begin // Data go out LSB first.
            rxd_out <= b[i];
            repeat (bit_cyc) @(posedge mclk_in);
        end
        if (pe) begin // Parity makes the ones count even or odd.
            rxd_out <= ^b ^ po ^ bad_par;
            repeat (bit_cyc) @(posedge mclk_in);
        end
        rxd_out <= ~bad_stop; // One high stop bit.
        repeat (bit_cyc) @(posedge mclk_in);
        rxd_out <= 1'b1;
    endtask
    // Samples one frame at bit centres and measures the start bit width.
    task automatic recv(input logic pe, input int lim, output logic [7:0] b,
                        output logic p, output logic stp, output int w);
        logic [9:0] fr;
        int t, k, n;
        n = 0;
        while (txd_in !== 1'b0 && n < lim) begin
            @(posedge mclk_in);
            n++;
        end
        t = 0;
        w = 0;
        k = 0;
        fr = 10'h0;
        while (k < 9 + int'(pe)) begin // Width counts to the first high bit.
            @(posedge mclk_in);
            t++;
            if (w == 0 && txd_in === 1'b1) w = t;
            if (t == bit_cyc / 2 + (k + 1) * bit_cyc) begin
                fr[k] = txd_in;
                k++;
            end
        end
        b = fr[7:0];
        p = fr[8];
        stp = fr[8 + int'(pe)];
    endtask
endmodule
`default_nettype wire

// File: tb/uart_autocal_baud_test.sv
// Self-checking bench: APB host, remote serial device and watchdog.
`timescale 1ns/10ps
`default_nettype none
`include "uab_cfg.svh"
module uart_autocal_baud_test;
    logic mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, txd, irq, rxd;
    logic [1:0] rc = 2'h0; // Divider whose top bit is the fast oscillator.
    logic [7:0] seed = 8'h36;
    logic [7:0] sent[$]; // Bytes sent to the block, newest last.
    int failures = 0, checks = 0;
    always #5 mclk = ~mclk;
    // The oscillator pin toggles every two clocks so bit times stay short.
    always @(posedge mclk) rc <= rc + 2'h1;
    uab_uart i_dut (.mclk_in(mclk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .rxd_in(rxd), .rosc_in(rc[1]),
        .txd_out(txd), .irq_out(irq));
    uab_far_end far (.mclk_in(mclk), .txd_in(txd), .rxd_out(rxd));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // One APB transfer; waits for ready as long as it takes, the watchdog ends a hang.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge mclk);
        psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge mclk);
        pen <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0; pen <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checks++;
        if (g !== x) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x);
    endtask
    // Sends a byte, tries a second one while busy, checks frame and flags.
    task automatic tx_one(input logic [7:0] d, input logic pe, input logic po, input int ew);
        logic [7:0] b;
        logic p, s;
        int w, n;
        fork
            far.recv(pe, 40000, b, p, s, w);
            begin
                wr(`UAB_OFF_DATA, {24'h0, d});
                wr(`UAB_OFF_DATA, {24'h0, ~d}); // A busy sender drops this.
                rd(`UAB_OFF_STATUS, 32'h20);
            end
        join
        chk({24'h0, b}, {24'h0, d});
        if (pe) chk({31'h0, p}, {31'h0, ^d ^ po});
        chk({31'h0, s}, 32'h1);
        if (ew != 0) chk(w, ew);
        n = 0;
        while (irq !== 1'b1 && n < 2000) begin
            @(posedge mclk);
            n++;
        end
        chk({31'h0, irq}, 32'h1);
        rd(`UAB_OFF_STATUS, 32'h2);
        wr(`UAB_OFF_STATUS, 32'h2);
        rd(`UAB_OFF_STATUS, 32'h0);
        chk({31'h0, irq}, 32'h0);
    endtask
    // Receives a byte with settings f = {bad stop, bad parity, odd, parity on}.
    task automatic rx_one(input logic [7:0] d, input logic [3:0] f, input logic [31:0] st);
        wr(`UAB_OFF_CMD, {26'h0, 2'b01, f[1], f[0], 2'b01});
        far.send(d, f[0], f[1], f[2], f[3]);
        sent.push_back(d);
        repeat (4) @(posedge mclk);
        chk({31'h0, irq}, 32'h1);
        rd(`UAB_OFF_STATUS, st);
        rd(`UAB_OFF_DATA, {24'h0, sent[$]});
        rd(`UAB_OFF_STATUS, st & ~32'h40);
        wr(`UAB_OFF_STATUS, 32'h1f);
        rd(`UAB_OFF_STATUS, 32'h0);
        chk({31'h0, irq}, 32'h0);
    endtask
    task automatic report_and_stop();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Watchdog: the sequence below needs about 35000 cycles; this allows 80000.
    initial begin
        #800000;
        failures++;
        report_and_stop();
    end
    initial begin
        logic [31:0] r;
        logic e;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        chk({30'h0, txd, irq}, 32'h2);
        rd(`UAB_OFF_CMD, 32'h0);
        rd(`UAB_OFF_BAUD, 32'h3);
        rd(`UAB_OFF_PRESC, 32'h28af);
        rd(`UAB_OFF_STATUS, 32'h0);
        apb(1'b0, 12'h014, 32'h0, r, e);
        chk(r, 32'h0);
        chk({31'h0, e}, 32'h1);
        wr(`UAB_OFF_CMD, 32'hffff_ffff);
        rd(`UAB_OFF_CMD, 32'h3f);
        // Oscillator pin as tick source, every parity mode.
        // The oscillator is divided from the system clock that times the far end, so no drift margin is needed.
        wr(`UAB_OFF_PRESC, 32'hf);
        for (int m = 0; m < 3; m++) begin
            wr(`UAB_OFF_CMD, {26'h0, 2'b01, m == 2, m != 0, 2'b10});
            seed = lfsr(seed);
            tx_one(seed, m != 0, m == 2, 0);
        end
        seed = lfsr(seed);
        rx_one(seed, 4'b0000, 32'h41);
        seed = lfsr(seed);
        rx_one(seed, 4'b0001, 32'h41);
        seed = lfsr(seed);
        rx_one(seed, 4'b0111, 32'h51);
        seed = lfsr(seed);
        rx_one(seed, 4'b1000, 32'h45);
        far.send(seed, 1'b0, 1'b0, 1'b0, 1'b0);
        seed = lfsr(seed);
        rx_one(seed, 4'b0000, 32'h49);
        // Calibrated rates, an index above the table, then the clamped prescaler.
        wr(`UAB_OFF_CMD, 32'h22);
        wr(`UAB_OFF_BAUD, 32'h8);
        far.bit_cyc = 100000000 / `UAB_RATE_8;
        tx_one(8'h55, 1'b0, 1'b0, 100000000 / `UAB_RATE_8);
        wr(`UAB_OFF_BAUD, 32'hf);
        far.bit_cyc = 100000000 / `UAB_RATE_9;
        tx_one(8'hb3, 1'b0, 1'b0, 100000000 / `UAB_RATE_9);
        wr(`UAB_OFF_CMD, 32'h02);
        wr(`UAB_OFF_PRESC, 32'h64);
        tx_one(8'h0f, 1'b0, 1'b0, 100000000 / `UAB_RATE_9);
        report_and_stop();
    end
endmodule
`default_nettype wire
